//--- core/stepper_pkg.sv
// shared constants and types for the stepper phase sequencer
package stepper_pkg;

  // electrical angle: 64 entries per period, 16 per quarter
  localparam int unsigned ANGLE_W    = 6;
  localparam int unsigned MAG_W      = 5;
  localparam int unsigned LEVEL_W    = 10;
  localparam logic [4:0]  MAG_FULL   = 5'h10;
  localparam logic [4:0]  MAG_DIAG   = 5'h08;
  localparam logic [5:0]  POS_INIT   = 6'h00;
  localparam logic [3:0]  DIAG_OFS   = 4'h8;

  // angle steps per mode, in table entries (16/N)
  localparam logic [5:0]  STEP_FULL  = 6'h10;
  localparam logic [5:0]  STEP_HALF  = 6'h08;
  localparam logic [5:0]  STEP_QUART = 6'h04;
  localparam logic [5:0]  STEP_EIGHT = 6'h02;
  localparam logic [5:0]  STEP_SIXT  = 6'h01;

  // current levels in tenths of a percent, index 0 to 16
  localparam logic [9:0] LEVEL_TABLE [0:16] = '{
    10'h000, 10'h062, 10'h0C3, 10'h122, 10'h17F, 10'h1D7, 10'h22C, 10'h27A,
    10'h2C3, 10'h305, 10'h33F, 10'h372, 10'h39C, 10'h3BD, 10'h3D5, 10'h3E3,
    10'h3E8
  };

  // fastest legal step clock is 200 kHz
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned STEP_PERIOD_MIN_NS = 5000;
  localparam int unsigned STEP_PERIOD_MIN_CYC =
    (STEP_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // step mode selections, bit1 bit2 bit3
  typedef enum logic [2:0] {
    MODE_STANDBY = 3'h0,
    MODE_FULL    = 3'h1,
    MODE_HALF_A  = 3'h2,
    MODE_HALF_B  = 3'h3,
    MODE_QUART   = 3'h4,
    MODE_EIGHT   = 3'h5,
    MODE_SIXT    = 3'h6,
    MODE_UNUSED  = 3'h7
  } step_mode_t;

  // drive states, gray along lockout -> off -> drive -> standby
  typedef enum logic [1:0] {
    ST_LOCKOUT = 2'h0,
    ST_OFF     = 2'h1,
    ST_DRIVE   = 2'h3,
    ST_STANDBY = 2'h2
  } drive_state_t;

endpackage

//--- core/sine_level_rom.sv
// phase magnitude index to sine-shaped current level
`timescale 1ns/1ps
module sine_level_rom (
  input  wire logic [4:0] mag_index,    // magnitude index 0 to 16
  output logic      [9:0] level_pmil    // level in tenths of a percent
);

  // table lookup, indices above 16 clamp to full level
  always_comb begin
    if (mag_index > stepper_pkg::MAG_FULL) begin
      level_pmil = stepper_pkg::LEVEL_TABLE[16];
    end else begin
      level_pmil = stepper_pkg::LEVEL_TABLE[mag_index];
    end
  end

endmodule

//--- core/stepper_phase_sequencer_status.sv
// microstep phase sequencer with fault and home status outputs
// Functional notes
// - fault flag pulled low on thermal/overcurrent
// - home flag pulled low at initial position
// - lockout forces outputs off, position initial
// - drive resumes by itself after lockout clears
// - mode 0,0,1 selects full step
// - mode 0,1,0 selects half step A
// - mode 0,1,1 selects half step B
// - mode 1,0,0 selects quarter step
// - mode 1,0,1 selects eighth step
// - mode 1,1,0 selects sixteenth step
// - index 0 to 16 maps to sine level
// - each step clock rising edge advances position, except in standby, lockout or with the reset pin low
// - enable low: outputs off, counter still runs
// - reset low holds A full, B zero
// - mode 0,0,0 enters standby
`timescale 1ns/1ps
module stepper_phase_sequencer_status (
  input  wire logic       clk,                   // 40 MHz system clock
  input  wire logic       resetn,                // synchronous reset, active low
  input  wire logic       step_clk,              // step clock from controller
  input  wire logic       rotation_dir,          // 1 clockwise, 0 counter-clockwise
  input  wire logic       step_mode_sel_bit1,    // mode select bit one
  input  wire logic       step_mode_sel_bit2,    // mode select bit two
  input  wire logic       step_mode_sel_bit3,    // mode select bit three
  input  wire logic       enable,                // output enable
  input  wire logic       seq_reset_n,           // sequencer reset pin, active low
  input  wire logic       supply_low_lockout,    // undervoltage lockout active
  input  wire logic       thermal_shutdown,      // thermal fault detected
  input  wire logic       overcurrent_detect,    // overcurrent fault detected
  output logic            fault_flag_n_out,      // open-drain level, always low
  output logic            fault_flag_n_oe,       // high while pulling fault low
  output logic            home_position_flag_out,// open-drain level, always low
  output logic            home_position_flag_oe, // high while pulling home low
  output logic            output_drive_en,       // bridges driven, else high-z
  output logic            standby_active,        // standby mode
  output logic      [5:0] angle_position,        // electrical angle 0 to 63
  output logic      [4:0] phase_a_index,         // phase A magnitude index
  output logic            phase_a_neg,           // phase A reverse direction
  output logic      [9:0] phase_a_level,         // phase A level, tenths of percent
  output logic      [4:0] phase_b_index,         // phase B magnitude index
  output logic            phase_b_neg,           // phase B reverse direction
  output logic      [9:0] phase_b_level          // phase B level, tenths of percent
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // decode of the three mode select pins
  function automatic stepper_pkg::step_mode_t decode_mode(input logic b1, input logic b2,
                                                          input logic b3);
    stepper_pkg::step_mode_t m;
    m = stepper_pkg::step_mode_t'({b1, b2, b3});
    return m;
  endfunction

  // magnitude of a phase, cos shape when is_a, else sin shape
  function automatic logic [4:0] phase_mag(input logic [5:0] pos, input logic is_a);
    logic [4:0] ofs;
    logic       even_q;
    ofs    = {1'b0, pos[3:0]};
    even_q = ~pos[4];
    if (even_q == is_a) begin
      phase_mag = stepper_pkg::MAG_FULL - ofs;
    end else begin
      phase_mag = ofs;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode, step and state

  stepper_pkg::step_mode_t   mode;           // decoded mode
  stepper_pkg::drive_state_t state_reg;      // drive state
  stepper_pkg::drive_state_t state_next;
  logic [5:0]                pos_reg;        // angle position
  logic [5:0]                pos_next;
  logic                      step_prev_reg;  // step clock last sample
  logic                      step_prev_next;
  logic [5:0]                step_size;      // entries per step
  logic                      step_edge;      // rising edge of step clock
  logic                      boost_diag;     // diagonal runs at full level

  assign mode = decode_mode(step_mode_sel_bit1, step_mode_sel_bit2, step_mode_sel_bit3);

  // step size and full-level diagonal choice per mode
  always_comb begin
    boost_diag = 1'b0;
    case (mode)
      stepper_pkg::MODE_FULL: begin
        step_size  = stepper_pkg::STEP_FULL;
        boost_diag = 1'b1;
      end
      // half step, diagonal at table level
      stepper_pkg::MODE_HALF_A: begin
        step_size = stepper_pkg::STEP_HALF;
      end
      stepper_pkg::MODE_HALF_B: begin
        step_size  = stepper_pkg::STEP_HALF;
        boost_diag = 1'b1;
      end
      stepper_pkg::MODE_QUART: begin
        step_size = stepper_pkg::STEP_QUART;
      end
      stepper_pkg::MODE_EIGHT: begin
        step_size = stepper_pkg::STEP_EIGHT;
      end
      stepper_pkg::MODE_SIXT: begin
        step_size = stepper_pkg::STEP_SIXT;
      end
      default: begin
        step_size = 6'h00;
      end
    endcase
  end

  assign step_edge = step_clk & ~step_prev_reg;

  // next drive state and position
  always_comb begin
    step_prev_next = step_clk;
    state_next     = state_reg;
    pos_next       = pos_reg;
    case (state_reg)
      stepper_pkg::ST_LOCKOUT: state_next = stepper_pkg::ST_OFF;
      stepper_pkg::ST_OFF:     state_next = stepper_pkg::ST_DRIVE;
      stepper_pkg::ST_DRIVE:   state_next = stepper_pkg::ST_DRIVE;
      stepper_pkg::ST_STANDBY: state_next = stepper_pkg::ST_OFF;
      default:                 state_next = stepper_pkg::ST_LOCKOUT;
    endcase
    // off or drive follows enable, no command needed
    if (!enable || thermal_shutdown || overcurrent_detect) begin
      // outputs off, counter keeps going below
      state_next = stepper_pkg::ST_OFF;
    end
    if (mode == stepper_pkg::MODE_STANDBY || mode == stepper_pkg::MODE_UNUSED) begin
      // standby, outputs off and sequencer held
      state_next = stepper_pkg::ST_STANDBY;
    end
    if (supply_low_lockout) begin
      state_next = stepper_pkg::ST_LOCKOUT;
    end
    if (supply_low_lockout || !seq_reset_n) begin
      // initial position, A full and B zero
      pos_next = stepper_pkg::POS_INIT;
    end else if (step_edge && step_size != 6'h00) begin
      if (mode == stepper_pkg::MODE_FULL && pos_reg[3:0] != stepper_pkg::DIAG_OFS) begin
        // first full step lands on the two-phase diagonal
        if (rotation_dir) begin
          pos_next = {pos_reg[5:4], stepper_pkg::DIAG_OFS}
                     + ((pos_reg[3:0] > stepper_pkg::DIAG_OFS) ? 6'h10 : 6'h00);
        end else begin
          pos_next = {pos_reg[5:4], stepper_pkg::DIAG_OFS}
                     - ((pos_reg[3:0] < stepper_pkg::DIAG_OFS) ? 6'h10 : 6'h00);
        end
      end else if (rotation_dir) begin
        pos_next = pos_reg + step_size;
      end else begin
        pos_next = pos_reg - step_size;
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg     <= stepper_pkg::ST_LOCKOUT;
      pos_reg       <= stepper_pkg::POS_INIT;
    end else begin
      state_reg     <= state_next;
      pos_reg       <= pos_next;
    end
    // edge detector tracks through reset
    // a step clock already high at release does not count, a rise just after it does
    step_prev_reg <= step_prev_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase currents and status outputs

  logic [4:0] mag_a;     // phase A magnitude
  logic [4:0] mag_b;     // phase B magnitude
  logic [9:0] lvl_a;     // phase A level
  logic [9:0] lvl_b;     // phase B level

  // B is the sine, a quarter period from A
  always_comb begin
    mag_a = phase_mag(pos_reg, 1'b1);
    mag_b = phase_mag(pos_reg, 1'b0);
    if (boost_diag && mag_a == stepper_pkg::MAG_DIAG) begin
      mag_a = stepper_pkg::MAG_FULL;
    end
    if (boost_diag && mag_b == stepper_pkg::MAG_DIAG) begin
      mag_b = stepper_pkg::MAG_FULL;
    end
  end

  sine_level_rom rom_a (
    .mag_index  (mag_a),
    .level_pmil (lvl_a)
  );

  sine_level_rom rom_b (
    .mag_index  (mag_b),
    .level_pmil (lvl_b)
  );

  // registered outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fault_flag_n_out       <= 1'b0;
      fault_flag_n_oe        <= 1'b0;
      home_position_flag_out <= 1'b0;
      home_position_flag_oe  <= 1'b1;
      output_drive_en        <= 1'b0;
      standby_active         <= 1'b0;
      angle_position         <= stepper_pkg::POS_INIT;
      phase_a_index          <= stepper_pkg::MAG_FULL;
      phase_a_neg            <= 1'b0;
      phase_a_level          <= stepper_pkg::LEVEL_TABLE[16];
      phase_b_index          <= 5'h00;
      phase_b_neg            <= 1'b0;
      phase_b_level          <= stepper_pkg::LEVEL_TABLE[0];
    end else begin
      fault_flag_n_out       <= 1'b0;
      fault_flag_n_oe        <= thermal_shutdown | overcurrent_detect;
      home_position_flag_out <= 1'b0;
      // pull low only at initial position
      home_position_flag_oe  <= (pos_reg == stepper_pkg::POS_INIT);
      output_drive_en        <= (state_reg == stepper_pkg::ST_DRIVE);
      standby_active         <= (state_reg == stepper_pkg::ST_STANDBY);
      angle_position         <= pos_reg;
      phase_a_index          <= mag_a;
      phase_a_neg            <= pos_reg[5] ^ pos_reg[4];
      phase_a_level          <= lvl_a;
      phase_b_index          <= mag_b;
      phase_b_neg            <= pos_reg[5];
      phase_b_level          <= lvl_b;
    end
  end

endmodule

//--- verif/stepper_seq_checker.sv
// port-level assertions for the stepper phase sequencer
`timescale 1ns/1ps
module stepper_seq_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       step_clk,
  input wire logic       rotation_dir,
  input wire logic       step_mode_sel_bit1,
  input wire logic       step_mode_sel_bit2,
  input wire logic       step_mode_sel_bit3,
  input wire logic       enable,
  input wire logic       seq_reset_n,
  input wire logic       supply_low_lockout,
  input wire logic       thermal_shutdown,
  input wire logic       overcurrent_detect,
  input wire logic       fault_flag_n_oe,
  input wire logic       home_position_flag_oe,
  input wire logic       output_drive_en,
  input wire logic [5:0] angle_position
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // mode select word, bit one first
  logic [2:0] mode;
  assign mode = {step_mode_sel_bit1, step_mode_sel_bit2, step_mode_sel_bit3};
  // a step taken in sixteenth mode, clockwise
  sequence sixt_fwd_step;
    $rose(step_clk) && mode == 3'h6 && rotation_dir && seq_reset_n && !supply_low_lockout;
  endsequence
  // standby selected with nothing else forcing the position
  sequence standby_held;
    (mode == 3'h0 && seq_reset_n && !supply_low_lockout) [*3];
  endsequence
  a_fault_follow: assert property (
    1'b1 |=> fault_flag_n_oe == $past(thermal_shutdown | overcurrent_detect))
    else $error("fault flag does not follow fault inputs");
  a_home_match: assert property (home_position_flag_oe == (angle_position == 6'h00))
    else $error("home flag disagrees with position");
  a_lockout_home: assert property (supply_low_lockout |-> ##2 angle_position == 6'h00)
    else $error("lockout did not return position to start");
  a_lockout_off: assert property (supply_low_lockout |-> ##2 !output_drive_en)
    else $error("lockout left bridges driven");
  a_enable_off: assert property ((!enable) [*2] |=> !output_drive_en)
    else $error("bridges driven with enable low");
  a_fault_off: assert property (
    (thermal_shutdown || overcurrent_detect) |-> ##2 !output_drive_en)
    else $error("bridges driven during fault");
  a_standby_hold: assert property (standby_held |=> $stable(angle_position))
    else $error("position moved in standby");
  a_step_one: assert property (
    sixt_fwd_step |-> ##3 angle_position == $past(angle_position, 3) + 6'h01)
    else $error("sixteenth step did not advance by one");
endmodule

//--- verif/step_ctrl_model.sv
// motion controller model issuing step clock pulses
`timescale 1ns/1ps
module step_ctrl_model #(
  parameter int HALF = 100
) (
  input  wire logic clk,       // bench clock
  output logic      step_clk   // step clock to the sequencer
);
  initial step_clk = 1'b0;
  // one step: low, rise, high, fall, settle; HALF cycles each
  // step rate kept low
  task automatic do_step();
    repeat (2) begin
      repeat (HALF) @(posedge clk);
      #1 step_clk = ~step_clk;
    end
    repeat (HALF) @(posedge clk);
    #1;
  endtask
endmodule

//--- verif/stepper_phase_sequencer_status_tb_top.sv
// self-checking testbench for the stepper phase sequencer
`timescale 1ns/1ps
module stepper_phase_sequencer_status_tb_top;
  logic       clk, resetn, step_clk, rotation_dir, enable, seq_reset_n;
  logic       b1, b2, b3, lockout, thermal, overcur;
  logic       fault_oe, home_oe, drive_en, standby;
  logic       fault_out, home_out, a_neg, b_neg;
  logic [4:0] a_idx, b_idx;
  logic [5:0] angle;
  logic [9:0] a_lvl, b_lvl;
  int         n_errors = 0;
  int         compares = 0;
  int         cycles   = 0;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  step_ctrl_model i_ctrl (.clk, .step_clk);

  stepper_phase_sequencer_status i_dut (
    .clk, .resetn, .step_clk, .rotation_dir, .enable, .seq_reset_n,
    .step_mode_sel_bit1(b1), .step_mode_sel_bit2(b2), .step_mode_sel_bit3(b3),
    .supply_low_lockout(lockout), .thermal_shutdown(thermal), .overcurrent_detect(overcur),
    .fault_flag_n_out(fault_out), .fault_flag_n_oe(fault_oe),
    .home_position_flag_out(home_out), .home_position_flag_oe(home_oe),
    .output_drive_en(drive_en), .standby_active(standby), .angle_position(angle),
    .phase_a_index(a_idx), .phase_a_neg(a_neg), .phase_a_level(a_lvl),
    .phase_b_index(b_idx), .phase_b_neg(b_neg), .phase_b_level(b_lvl)
  );

  task automatic chk(string what, logic [9:0] seen, logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // sequencer reset pin back to the start position
  task automatic home();
    seq_reset_n = 1'b0;
    tick(3);
    chk("start angle", 10'(angle), 10'h000);
    chk("start level a", a_lvl, 10'h3E8);
    chk("start level b", b_lvl, 10'h000);
    seq_reset_n = 1'b1;
    tick(1);
  endtask

  // each of the six step modes: one step forward, two back
  task automatic t_modes();
    logic [2:0] md [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [5:0] fw [6] = '{6'h08, 6'h08, 6'h08, 6'h04, 6'h02, 6'h01};
    logic [5:0] bk [6] = '{6'h28, 6'h38, 6'h38, 6'h3C, 6'h3E, 6'h3F};
    logic [9:0] lv [6] = '{10'h3E8, 10'h2C3, 10'h3E8, 10'h39C, 10'h3D5, 10'h3E3};
    logic       an [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      {b1, b2, b3} = md[i];
      home();
      rotation_dir = 1'b1;
      i_ctrl.do_step();
      chk("angle fwd", 10'(angle), 10'(fw[i]));
      chk("level fwd", a_lvl, lv[i]);
      chk("home off", 10'(home_oe), 10'h000);
      rotation_dir = 1'b0;
      i_ctrl.do_step();
      i_ctrl.do_step();
      chk("angle back", 10'(angle), 10'(bk[i]));
      chk("neg a", 10'(a_neg), 10'(an[i]));
      chk("neg b", 10'(b_neg), 10'h001);
    end
  endtask

  // sixteenth steps across a quarter period
  task automatic t_levels();
    {b1, b2, b3} = 3'h6;
    home();
    rotation_dir = 1'b1;
    for (int k = 1; k <= 16; k++) begin
      i_ctrl.do_step();
      chk("level a", a_lvl, stepper_pkg::LEVEL_TABLE[16-k]);
      chk("level b", b_lvl, stepper_pkg::LEVEL_TABLE[k]);
      chk("index a", 10'(a_idx), 10'(16 - k));
      chk("index b", 10'(b_idx), 10'(k));
    end
  endtask

  // standby refuses steps and drops drive
  task automatic t_standby();
    {b1, b2, b3} = 3'h0;
    tick(4);
    chk("standby", 10'(standby), 10'h001);
    chk("drive", 10'(drive_en), 10'h000);
    i_ctrl.do_step();
    chk("angle held", 10'(angle), 10'h010);
    {b1, b2, b3} = 3'h6;
    tick(4);
  endtask

  // fault flag combinations, then enable low
  task automatic t_faults();
    for (int f = 0; f < 4; f++) begin
      {thermal, overcur} = 2'(f);
      tick(4);
      chk("fault", 10'(fault_oe), 10'(f != 0));
      chk("fault level", 10'(fault_out), 10'h000);
      chk("drive", 10'(drive_en), 10'(f == 0));
    end
    {thermal, overcur} = 2'h0;
    enable = 1'b0;
    tick(4);
    chk("drive off", 10'(drive_en), 10'h000);
    i_ctrl.do_step();
    chk("angle counts", 10'(angle), 10'h011);
    enable = 1'b1;
  endtask

  // lockout holds start, then drive resumes unaided
  task automatic t_lockout();
    lockout = 1'b1;
    tick(4);
    chk("lock angle", 10'(angle), 10'h000);
    chk("lock drive", 10'(drive_en), 10'h000);
    chk("lock home", 10'(home_oe), 10'h001);
    chk("home level", 10'(home_out), 10'h000);
    i_ctrl.do_step();
    chk("lock step", 10'(angle), 10'h000);
    lockout = 1'b0;
    tick(5);
    chk("resume", 10'(drive_en), 10'h001);
    i_ctrl.do_step();
    chk("resume step", 10'(angle), 10'h001);
  endtask

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    resetn = 1'b0;
    rotation_dir = 1'b1;
    enable = 1'b1;
    seq_reset_n = 1'b1;
    {b1, b2, b3} = 3'h1;
    {lockout, thermal, overcur} = 3'h0;
    tick(2);
    chk("reset angle", 10'(angle), 10'h000);
    chk("reset b", b_lvl, 10'h000);
    resetn = 1'b1;
    t_modes();
    t_levels();
    t_standby();
    t_faults();
    t_lockout();
    wrap_up();
  end
endmodule

bind stepper_phase_sequencer_status stepper_seq_checker i_chk (
  .clk, .resetn, .step_clk, .rotation_dir, .step_mode_sel_bit1, .step_mode_sel_bit2,
  .step_mode_sel_bit3, .enable, .seq_reset_n, .supply_low_lockout, .thermal_shutdown,
  .overcurrent_detect, .fault_flag_n_oe, .home_position_flag_oe, .output_drive_en,
  .angle_position
);
